// ==== hdl/efp_regs.vh ====
// constants for the embedder front panel control block
`ifndef EFP_REGS_VH
`define EFP_REGS_VH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EFP_CLK_HZ          10000000
`define EFP_COMMIT_S        15
`define EFP_COMMIT_CYC      (`EFP_COMMIT_S * `EFP_CLK_HZ)
`define EFP_DEBOUNCE_MS     10
`define EFP_DEBOUNCE_CYC    ((`EFP_DEBOUNCE_MS * `EFP_CLK_HZ) / 1000)
`define EFP_BLINK_MS        250
`define EFP_BLINK_CYC       ((`EFP_BLINK_MS * `EFP_CLK_HZ) / 1000)
`define EFP_DELAY_MAX_MS    1000

// ------------------------------------------------------------
// modes and field codes
// ------------------------------------------------------------
`define EFP_MODE_MUX        1'b0
`define EFP_MODE_DEMUX      1'b1
`define EFP_SUB_REPLACE     1'b0
`define EFP_SUB_CASCADE     1'b1
`define EFP_REF_18          1'b0
`define EFP_REF_20          1'b1
`define EFP_GAIN_UNITY      3'h0
`define EFP_GAIN_MAX        3'h4
`define EFP_PEAK_MAX        3'h5
`define EFP_SAMPLE_W        24
`define EFP_LEVEL_W         8

// ------------------------------------------------------------
// edit sections
// ------------------------------------------------------------
`define EFP_SEC_IDLE        2'h0
`define EFP_SEC_MODE        2'h1
`define EFP_SEC_GROUP       2'h2
`define EFP_SEC_GAIN        2'h3

// ------------------------------------------------------------
// led colour codes
// ------------------------------------------------------------
`define EFP_LED_OFF         2'h0
`define EFP_LED_GREEN       2'h1
`define EFP_LED_RED         2'h2
`define EFP_LED_ORANGE      2'h3

// ------------------------------------------------------------
// stored settings layout
// ------------------------------------------------------------
`define EFP_NV_W            16
`define EFP_NV_MODE         0
`define EFP_NV_SUB          1
`define EFP_NV_REF          2
`define EFP_NV_GRP_LO       3
`define EFP_NV_GAIN_LO      5

`endif

// ==== hdl/efp_buf2.v ====
// two-entry valid/ready buffer for the audio sample path
`timescale 1ns/1ns
module efp_buf2 #(
  parameter W = 24
) (
  input  wire         sys_clk_i,
  input  wire         srst_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:1];
  reg         wp;
  reg         rp;
  reg [1:0]   cnt;
  reg         not_full;
  wire        push;
  wire        pop;

  assign in_ready_o  = not_full;
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o  = mem[rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
      not_full <= 1'b1;
    end else begin
      if (push) begin
        mem[wp] <= in_data_i;
        wp      <= ~wp;
      end
      if (pop)
        rp <= ~rp;
      if (push & ~pop) begin
        cnt      <= cnt + 2'h1;
        not_full <= (cnt != 2'h1);
      end else if (pop & ~push) begin
        cnt      <= cnt - 2'h1;
        not_full <= 1'b1;
      end
    end
  end
endmodule // efp_buf2

// ==== hdl/efp_ctrl.v ====
// front panel control and status for the audio embedder
`timescale 1ns/1ns
`include "efp_regs.vh"
module efp_ctrl #(
  parameter COMMIT_CYC   = `EFP_COMMIT_CYC,
  parameter DEBOUNCE_CYC = `EFP_DEBOUNCE_CYC,
  parameter BLINK_CYC    = `EFP_BLINK_CYC
) (
  input  wire                     sys_clk_i,
  input  wire                     srst_i,
  input  wire                     btn_mode_i,
  input  wire                     btn_right_i,
  input  wire                     btn_left_i,
  input  wire                     video_valid_i,
  input  wire                     pwr_good_i,
  input  wire [3:0]               group_present_i,
  input  wire [`EFP_NV_W-1:0]     nv_rd_data_i,
  input  wire                     nv_rd_valid_i,
  input  wire                     sub_mode_i,
  input  wire                     strip_i,
  input  wire [2:0]               peak_sel_i,
  input  wire [9:0]               delay_ms_i,
  input  wire [4*`EFP_LEVEL_W-1:0] level_db_i,
  input  wire                     smp_valid_i,
  output wire                     smp_ready_o,
  input  wire [`EFP_SAMPLE_W-1:0] smp_data_i,
  output reg                      smp_valid_o,
  input  wire                     smp_ready_i,
  output reg  [`EFP_SAMPLE_W-1:0] smp_data_o,
  output reg                      aes_dir_out_o,
  output reg                      aes_dir_valid_o,
  output reg                      src_enable_o,
  output reg                      embed_enable_o,
  output reg                      embed_cascade_o,
  output reg                      strip_audio_o,
  output reg                      strip_error_detection_packet_o,
  output reg  [1:0]               group_sel_o,
  output reg  [9:0]               delay_ms_o,
  output reg  [11:0]              pair_gain_o,
  output reg  [1:0]               led_in_o,
  output reg  [1:0]               led_mux_o,
  output reg  [1:0]               led_demux_o,
  output reg  [7:0]               led_group_o,
  output reg  [7:0]               led_vu_o,
  output reg  [7:0]               led_gain_o,
  output reg  [1:0]               led_pwr_o,
  output reg                      nv_rd_req_o,
  output reg                      nv_wr_o,
  output reg  [`EFP_NV_W-1:0]     nv_wr_data_o
);

  // ------------------------------------------------------------
  // input synchronisers and debounce
  // ------------------------------------------------------------
  reg  [2:0] btn_s1;
  reg  [2:0] btn_s2;
  reg  [2:0] btn_db;
  reg  [2:0] btn_press;
  reg  [1:0] vid_s;
  reg  [1:0] pwr_s;
  reg  [3:0] grp_s1;
  reg  [3:0] grp_s2;
  wire [2:0] btn_raw = {btn_left_i, btn_right_i, btn_mode_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_btn
      reg [19:0] db_cnt;
      always @(posedge sys_clk_i) begin
        if (srst_i) begin
          db_cnt        <= 20'h0;
          btn_db[gi]    <= 1'b0;
          btn_press[gi] <= 1'b0;
        end else begin
          btn_press[gi] <= 1'b0;
          if (btn_s2[gi] == btn_db[gi]) begin
            db_cnt <= 20'h0;
          end else if (db_cnt == DEBOUNCE_CYC[19:0] - 20'h1) begin
            db_cnt        <= 20'h0;
            btn_db[gi]    <= btn_s2[gi];
            btn_press[gi] <= btn_s2[gi];
          end else begin
            db_cnt <= db_cnt + 20'h1;
          end
        end
      end
    end
  endgenerate

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      btn_s1 <= 3'h0;
      btn_s2 <= 3'h0;
      vid_s  <= 2'h0;
      pwr_s  <= 2'h0;
      grp_s1 <= 4'h0;
      grp_s2 <= 4'h0;
    end else begin
      btn_s1 <= btn_raw;
      btn_s2 <= btn_s1;
      vid_s  <= {vid_s[0], video_valid_i};
      pwr_s  <= {pwr_s[0], pwr_good_i};
      grp_s1 <= group_present_i;
      grp_s2 <= grp_s1;
    end
  end

  // ------------------------------------------------------------
  // settings, restore and edit
  // ------------------------------------------------------------
  localparam ST_LOAD_REQ  = 2'h0;
  localparam ST_LOAD_WAIT = 2'h1;
  localparam ST_RUN       = 2'h2;

  reg  [1:0]  state;
  reg         mode;
  reg         ref_sel;
  reg  [1:0]  group;
  reg  [11:0] gain;
  reg  [1:0]  section;
  reg  [1:0]  pair_cur;
  reg  [31:0] commit_cnt;
  reg         pending;
  reg  [2:0]  edit_gain;
  wire        any_press = |btn_press;
  wire [2:0]  gain_cur = gain[pair_cur*3 +: 3];
  // stored gain: a step code above the limit voids every pair
  wire [11:0] gain_ld  = {1'b0, nv_rd_data_i[`EFP_NV_W-1:`EFP_NV_GAIN_LO]};
  wire        gain_bad = (gain_ld[2] & |gain_ld[1:0]) | (gain_ld[5] & |gain_ld[4:3])
                         | (gain_ld[8] & |gain_ld[7:6]) | (gain_ld[11] & |gain_ld[10:9]);

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      state       <= ST_LOAD_REQ;
      mode        <= `EFP_MODE_MUX;
      ref_sel     <= `EFP_REF_18;
      group       <= 2'h0;
      gain        <= 12'h0;
      section     <= `EFP_SEC_IDLE;
      pair_cur    <= 2'h0;
      commit_cnt  <= 32'h0;
      pending     <= 1'b0;
      nv_rd_req_o <= 1'b0;
      nv_wr_o     <= 1'b0;
      nv_wr_data_o <= 16'h0;
    end else begin
      nv_rd_req_o <= 1'b0;
      nv_wr_o     <= 1'b0;
      case (state)
        ST_LOAD_REQ: begin
          nv_rd_req_o <= 1'b1;
          state       <= ST_LOAD_WAIT;
        end
        ST_LOAD_WAIT: begin
          if (nv_rd_valid_i) begin
            mode    <= nv_rd_data_i[`EFP_NV_MODE];
            ref_sel <= nv_rd_data_i[`EFP_NV_REF];
            group   <= nv_rd_data_i[`EFP_NV_GRP_LO +: 2];
            gain    <= gain_bad ? 12'h0 : gain_ld;
            state   <= ST_RUN;
          end
        end
        default: begin
          if (btn_press[0]) begin
            section  <= (section == `EFP_SEC_GAIN) ? `EFP_SEC_MODE : section + 2'h1;
            pair_cur <= 2'h0;
          end else if (section != `EFP_SEC_IDLE && (btn_press[1] || btn_press[2])) begin
            pending    <= 1'b1;
            commit_cnt <= 32'h0;
            case (section)
              `EFP_SEC_MODE:  mode  <= ~mode;
              `EFP_SEC_GROUP: group <= btn_press[1] ? group + 2'h1 : group - 2'h1;
              default: begin
                if (btn_press[1] && gain_cur == `EFP_GAIN_MAX)
                  pair_cur <= pair_cur + 2'h1;
                else if (btn_press[1])
                  gain[pair_cur*3 +: 3] <= gain_cur + 3'h1;
                else if (gain_cur != `EFP_GAIN_UNITY)
                  gain[pair_cur*3 +: 3] <= gain_cur - 3'h1;
                else
                  pair_cur <= pair_cur - 2'h1;
              end
            endcase
          end else if (pending) begin
            if (commit_cnt == COMMIT_CYC - 1) begin
              pending      <= 1'b0;
              section      <= `EFP_SEC_IDLE;
              nv_wr_o      <= 1'b1;
              nv_wr_data_o <= {gain[10:0], group, ref_sel, sub_mode_i, mode}; // top gain bit does not fit
            end else begin
              commit_cnt <= commit_cnt + 32'h1;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // blink enable
  // ------------------------------------------------------------
  reg [23:0] blink_cnt;
  reg        blink;
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      blink_cnt <= 24'h0;
      blink     <= 1'b0;
    end else if (blink_cnt == BLINK_CYC - 1) begin
      blink_cnt <= 24'h0;
      blink     <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 24'h1;
    end
  end

  // ------------------------------------------------------------
  // datapath control
  // ------------------------------------------------------------
  wire run = (state == ST_RUN);
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      aes_dir_out_o   <= 1'b0;
      aes_dir_valid_o <= 1'b0;
      src_enable_o    <= 1'b0;
      embed_enable_o  <= 1'b0;
      embed_cascade_o <= 1'b0;
      strip_audio_o   <= 1'b0;
      strip_error_detection_packet_o <= 1'b0;
      group_sel_o     <= 2'h0;
      delay_ms_o      <= 10'h0;
      pair_gain_o     <= 12'h0;
    end else begin
      aes_dir_valid_o <= run;
      aes_dir_out_o   <= run & (mode == `EFP_MODE_DEMUX);
      src_enable_o    <= run & (mode == `EFP_MODE_MUX);
      embed_enable_o  <= run & (mode == `EFP_MODE_MUX);
      embed_cascade_o <= sub_mode_i == `EFP_SUB_CASCADE;
      strip_audio_o   <= strip_i;
      strip_error_detection_packet_o <= strip_i;
      group_sel_o     <= group;
      delay_ms_o      <= (delay_ms_i > `EFP_DELAY_MAX_MS) ? 10'd1000 : delay_ms_i;
      pair_gain_o     <= gain;
    end
  end

  // ------------------------------------------------------------
  // sample path buffer
  // ------------------------------------------------------------
  wire                     b_valid;
  wire [`EFP_SAMPLE_W-1:0] b_data;
  wire                     b_ready = ~smp_valid_o | smp_ready_i;

  efp_buf2 #(.W(`EFP_SAMPLE_W)) u_buf (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (smp_valid_i),
    .in_ready_o  (smp_ready_o),
    .in_data_i   (smp_data_i),
    .out_valid_o (b_valid),
    .out_ready_i (b_ready),
    .out_data_o  (b_data)
  );

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      smp_valid_o <= 1'b0;
      smp_data_o  <= 24'h0;
    end else if (b_ready) begin
      smp_valid_o <= b_valid;
      smp_data_o  <= b_data;
    end
  end

  // ------------------------------------------------------------
  // indicators
  // ------------------------------------------------------------
  // level inputs: dB below full scale per pair; threshold in same units
  wire [7:0] peak_db = (peak_sel_i > `EFP_PEAK_MAX) ? 8'h0 : {4'h0, peak_sel_i, 1'b0};
  wire [7:0] zero_vu = (ref_sel == `EFP_REF_20) ? 8'd20 : 8'd18;
  wire [7:0] m20_vu  = zero_vu + 8'd20;
  wire       blink_mode = pending & (section == `EFP_SEC_MODE) & blink;
  wire       blink_grp  = pending & (section == `EFP_SEC_GROUP) & blink;
  wire       blink_gain = pending & (section == `EFP_SEC_GAIN) & blink;
  reg  [7:0] next_vu;
  reg  [7:0] next_gain;
  reg  [7:0] next_group;
  integer    p;

  always @* begin
    next_vu    = 8'h0;
    next_gain  = 8'h0;
    next_group = 8'h0;
    for (p = 0; p < 4; p = p + 1) begin
      if (level_db_i[p*8 +: 8] <= peak_db)
        next_vu[p*2 +: 2] = `EFP_LED_RED;
      else if (level_db_i[p*8 +: 8] < zero_vu)
        next_vu[p*2 +: 2] = `EFP_LED_ORANGE;
      else if (level_db_i[p*8 +: 8] <= m20_vu)
        next_vu[p*2 +: 2] = `EFP_LED_GREEN;
      if (gain[p*3 +: 3] != `EFP_GAIN_UNITY && !(blink_gain && pair_cur == p[1:0]))
        next_gain[p*2 +: 2] = `EFP_LED_RED;
    end
    if (!blink_grp)
      next_group[group*2 +: 2] = grp_s2[group] ? `EFP_LED_GREEN : `EFP_LED_RED;
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      led_in_o    <= 2'h0;
      led_mux_o   <= 2'h0;
      led_demux_o <= 2'h0;
      led_group_o <= 8'h0;
      led_vu_o    <= 8'h0;
      led_gain_o  <= 8'h0;
      led_pwr_o   <= 2'h0;
    end else begin
      led_in_o    <= vid_s[1] ? `EFP_LED_GREEN : `EFP_LED_OFF;
      led_mux_o   <= (run && mode == `EFP_MODE_MUX && !blink_mode) ? `EFP_LED_GREEN : `EFP_LED_OFF;
      led_demux_o <= (run && mode == `EFP_MODE_DEMUX && !blink_mode) ? `EFP_LED_GREEN : `EFP_LED_OFF;
      led_group_o <= run ? next_group : 8'h0;
      led_vu_o    <= next_vu;
      led_gain_o  <= next_gain;
      led_pwr_o   <= pwr_s[1] ? `EFP_LED_GREEN : `EFP_LED_OFF;
    end
  end

endmodule // efp_ctrl

// ==== verification/efp_ctrl_sva.sv ====
// assertions for the front panel control block
`timescale 1ns/1ns
`include "efp_regs.vh"
module efp_ctrl_sva (
  input wire        sys_clk_i,
  input wire        srst_i,
  input wire        video_valid_i,
  input wire [3:0]  group_present_i,
  input wire        nv_rd_valid_i,
  input wire        sub_mode_i,
  input wire        strip_i,
  input wire        smp_valid_o,
  input wire        smp_ready_i,
  input wire [23:0] smp_data_o,
  input wire        aes_dir_out_o,
  input wire        aes_dir_valid_o,
  input wire        src_enable_o,
  input wire        embed_enable_o,
  input wire        embed_cascade_o,
  input wire        strip_audio_o,
  input wire        strip_error_detection_packet_o,
  input wire [1:0]  group_sel_o,
  input wire [9:0]  delay_ms_o,
  input wire [11:0] pair_gain_o,
  input wire [1:0]  led_in_o,
  input wire [1:0]  led_mux_o,
  input wire [1:0]  led_demux_o,
  input wire [7:0]  led_group_o,
  input wire        nv_rd_req_o,
  input wire        nv_wr_o
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_dir_by_mode: assert property (aes_dir_valid_o |-> aes_dir_out_o != src_enable_o)
    else $error("port direction disagrees with mode");
  a_embed_in_mux: assert property (aes_dir_valid_o |-> embed_enable_o == src_enable_o)
    else $error("embedding not tied to mux mode");
  a_no_dir_early: assert property (!aes_dir_valid_o |-> !src_enable_o && !embed_enable_o)
    else $error("mode driven before restore");
  a_restore_after_read: assert property (nv_rd_valid_i && !aes_dir_valid_o |-> ##[1:2] aes_dir_valid_o)
    else $error("restore did not complete");
  a_read_once: assert property ($fell(srst_i) |-> ##[1:2] nv_rd_req_o ##1 !nv_rd_req_o)
    else $error("settings read not issued as one pulse");
  a_cascade_follow: assert property (!$past(srst_i) |-> embed_cascade_o == $past(sub_mode_i))
    else $error("cascade does not follow sub mode");
  a_strip_follow: assert property (!$past(srst_i) |-> strip_audio_o == $past(strip_i)
    && strip_error_detection_packet_o == $past(strip_i))
    else $error("strip outputs do not follow strip setting");
  a_mode_led_sel: assert property ((aes_dir_valid_o && $stable(aes_dir_out_o)) [*2]
    |-> (aes_dir_out_o ? {led_mux_o, led_demux_o[1]} : {led_demux_o, led_mux_o[1]}) == 3'h0)
    else $error("wrong mode led lit");
  a_input_led: assert property (($stable(video_valid_i) && aes_dir_valid_o) [*5]
    |-> led_in_o == (video_valid_i ? `EFP_LED_GREEN : `EFP_LED_OFF))
    else $error("input led wrong");
  a_group_led: assert property (($stable(group_present_i) && $stable(group_sel_o) && aes_dir_valid_o) [*5]
    |-> led_group_o[2*group_sel_o +: 2] == `EFP_LED_OFF
    || led_group_o[2*group_sel_o +: 2] == (group_present_i[group_sel_o] ? `EFP_LED_GREEN : `EFP_LED_RED))
    else $error("group led wrong");
  a_out_hold: assert property (smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_data_o))
    else $error("sample dropped or changed under stall");
  a_delay_clamp: assert property (delay_ms_o <= 10'h3e8)
    else $error("delay above one second");
  a_gain_limit: assert property (pair_gain_o[2:0] <= 3'h4 && pair_gain_o[5:3] <= 3'h4
    && pair_gain_o[8:6] <= 3'h4 && pair_gain_o[11:9] <= 3'h4)
    else $error("gain above limit");
  a_wr_pulse: assert property (nv_wr_o |=> !nv_wr_o)
    else $error("store write longer than one cycle");
endmodule // efp_ctrl_sva

bind efp_ctrl efp_ctrl_sva u_sva (.sys_clk_i, .srst_i, .video_valid_i, .group_present_i, .nv_rd_valid_i,
  .sub_mode_i, .strip_i, .smp_valid_o, .smp_ready_i, .smp_data_o, .aes_dir_out_o, .aes_dir_valid_o,
  .src_enable_o, .embed_enable_o, .embed_cascade_o, .strip_audio_o, .strip_error_detection_packet_o,
  .group_sel_o, .delay_ms_o, .pair_gain_o, .led_in_o, .led_mux_o, .led_demux_o, .led_group_o,
  .nv_rd_req_o, .nv_wr_o);

// ==== verification/efp_far_model.sv ====
// far side model: settings store and audio sample sink
`timescale 1ns/1ns
module efp_far_model #(
  parameter [15:0] STORED = 16'h0050
) (
  input  wire        sys_clk_i,
  input  wire        nv_rd_req_i,
  output reg  [15:0] nv_rd_data_o,
  output reg         nv_rd_valid_o,
  input  wire        stall_i,
  output reg         smp_ready_o
);
  reg [2:0] wait_cnt;
  reg       reread;
  initial begin
    reread = 1'b0;
    nv_rd_data_o = 16'h0;
    nv_rd_valid_o = 1'b0;
    smp_ready_o = 1'b0;
    wait_cnt = 3'h0;
  end
  always @(negedge sys_clk_i) begin
    nv_rd_valid_o <= 1'b0;
    // store output does not hold outside its answer
    nv_rd_data_o <= ~nv_rd_data_o;
    if (nv_rd_req_i) begin
      wait_cnt <= 3'h4;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
      if (wait_cnt == 3'h1) begin
        nv_rd_valid_o <= 1'b1;
        // later reads return the other reference level
        nv_rd_data_o <= reread ? STORED ^ 16'h0004 : STORED;
        reread <= 1'b1;
      end
    end
    smp_ready_o <= !stall_i && ($urandom_range(3) != 0);
  end
endmodule // efp_far_model

// ==== verification/efp_ctrl_tb.sv ====
// self-checking testbench for the front panel control block
`timescale 1ns/1ns
`include "efp_regs.vh"
module efp_ctrl_tb;
  reg         sys_clk_i = 1'b0, srst_i = 1'b1, stall = 1'b0, pwr_good_i = 1'b1;
  reg         btn_mode_i = 1'b0, btn_right_i = 1'b0, btn_left_i = 1'b0, smp_valid_i = 1'b0;
  reg         video_valid_i = 1'b0, sub_mode_i = 1'b0, strip_i = 1'b0;
  reg  [3:0]  group_present_i = 4'h0;
  reg  [2:0]  peak_sel_i = 3'h0;
  reg  [9:0]  delay_ms_i = 10'h0;
  reg  [31:0] level_db_i = 32'h0;
  reg  [23:0] smp_data_i = 24'h0;
  wire [15:0] nv_rd_data, nv_wr_data_o;
  wire        nv_rd_valid, nv_rd_req_o, nv_wr_o, smp_ready_o, smp_valid_o, smp_ready_i;
  wire        aes_dir_out_o, aes_dir_valid_o, src_enable_o;
  wire        embed_enable_o, embed_cascade_o, strip_audio_o, strip_error_detection_packet_o;
  wire [23:0] smp_data_o;
  wire [9:0]  delay_ms_o;
  wire [11:0] pair_gain_o;
  wire [1:0]  group_sel_o, led_in_o, led_mux_o, led_demux_o, led_pwr_o;
  wire [7:0]  led_group_o, led_vu_o, led_gain_o;
  integer     mismatches = 0, tests_run = 0, i, n;
  reg  [23:0] expq[$];

  always #50 sys_clk_i = ~sys_clk_i;

  efp_ctrl #(.COMMIT_CYC(50), .DEBOUNCE_CYC(3), .BLINK_CYC(4)) DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .btn_mode_i(btn_mode_i), .btn_right_i(btn_right_i), .btn_left_i(btn_left_i), .video_valid_i(video_valid_i),
    .pwr_good_i(pwr_good_i), .group_present_i(group_present_i), .nv_rd_data_i(nv_rd_data),
    .nv_rd_valid_i(nv_rd_valid), .sub_mode_i(sub_mode_i), .strip_i(strip_i), .peak_sel_i(peak_sel_i),
    .delay_ms_i(delay_ms_i), .level_db_i(level_db_i), .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o),
    .smp_data_i(smp_data_i), .smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i), .smp_data_o(smp_data_o),
    .aes_dir_out_o(aes_dir_out_o), .aes_dir_valid_o(aes_dir_valid_o), .src_enable_o(src_enable_o),
    .embed_enable_o(embed_enable_o), .embed_cascade_o(embed_cascade_o), .strip_audio_o(strip_audio_o),
    .strip_error_detection_packet_o(strip_error_detection_packet_o),
    .group_sel_o(group_sel_o), .delay_ms_o(delay_ms_o), .pair_gain_o(pair_gain_o), .led_in_o(led_in_o),
    .led_mux_o(led_mux_o), .led_demux_o(led_demux_o), .led_group_o(led_group_o), .led_vu_o(led_vu_o),
    .led_gain_o(led_gain_o), .led_pwr_o(led_pwr_o), .nv_rd_req_o(nv_rd_req_o), .nv_wr_o(nv_wr_o),
    .nv_wr_data_o(nv_wr_data_o));

  efp_far_model #(.STORED(16'h0050)) u_far (.sys_clk_i(sys_clk_i), .nv_rd_req_i(nv_rd_req_o),
    .nv_rd_data_o(nv_rd_data), .nv_rd_valid_o(nv_rd_valid), .stall_i(stall), .smp_ready_o(smp_ready_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input [31:0] seen, input [31:0] want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task press(input integer b);
    begin
      {btn_left_i, btn_right_i, btn_mode_i} = 3'h1 << b;
      cyc(10);
      {btn_left_i, btn_right_i, btn_mode_i} = 3'h0;
      cyc(10);
    end
  endtask
  task commit(input [15:0] mask, input [15:0] want);
    begin
      n = 0;
      while (nv_wr_o !== 1'b1 && n < 200) begin
        cyc(1);
        n = n + 1;
      end
      check(n >= 25 && n <= 60, 1);
      check(nv_wr_data_o & mask, want);
      cyc(2);
    end
  endtask
  function [1:0] vu(input [7:0] lvl, input [2:0] sel);
    reg [7:0] pk;
    begin
      pk = (sel > 3'h5) ? 8'h0 : {4'h0, sel, 1'b0};
      if (lvl <= pk) vu = `EFP_LED_RED;
      else if (lvl < 8'h12) vu = `EFP_LED_ORANGE;
      else if (lvl <= 8'h26) vu = `EFP_LED_GREEN;
      else vu = `EFP_LED_OFF;
    end
  endfunction
  task print_verdict;
    begin
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask

  // output watcher: oldest noted sample against each delivered one
  always @(posedge sys_clk_i) begin
    if (smp_valid_o === 1'b1 && smp_ready_i === 1'b1) begin
      check(expq.size() != 0, 1);
      if (expq.size() != 0) check(smp_data_o, expq.pop_front());
    end
  end

  initial begin
    #(100 * 20000);
    mismatches = mismatches + 1;
    print_verdict;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    n = $urandom(32'h59c664e3);
    cyc(10);
    srst_i = 1'b0;
    cyc(20);
    check(aes_dir_valid_o, 1);
    check({aes_dir_out_o, src_enable_o}, 1);
    check(group_sel_o, 2);
    check(pair_gain_o, 12'h002);
    check(led_gain_o, 8'h02);
    for (i = 0; i < 48; i = i + 1) begin
      peak_sel_i = i[2:0];
      level_db_i = $urandom & 32'h3f3f3f3f;
      delay_ms_i = $urandom_range(1023);
      {video_valid_i, sub_mode_i, strip_i, pwr_good_i, group_present_i} = $urandom;
      cyc(6);
      for (n = 0; n < 4; n = n + 1) check(led_vu_o[2*n +: 2], vu(level_db_i[8*n +: 8], peak_sel_i));
      check(delay_ms_o, delay_ms_i > 10'h3e8 ? 10'h3e8 : delay_ms_i);
      check(led_pwr_o, pwr_good_i ? `EFP_LED_GREEN : `EFP_LED_OFF);
      check({strip_audio_o, strip_error_detection_packet_o}, {2{strip_i}});
      check({embed_enable_o, embed_cascade_o}, {1'b1, sub_mode_i});
      check(led_in_o, video_valid_i ? `EFP_LED_GREEN : `EFP_LED_OFF);
      check(led_group_o, group_present_i[2] ? 8'h10 : 8'h20);
    end
    pwr_good_i = 1'b1;
    for (i = 0; i < 40; i = i + 1) begin
      smp_valid_i = 1'b1;
      smp_data_i = $urandom;
      @(posedge sys_clk_i);
      while (smp_ready_o !== 1'b1) @(posedge sys_clk_i);
      expq.push_back(smp_data_i);
      @(negedge sys_clk_i);
      if (i[0] || i == 39) begin
        smp_valid_i = 1'b0;
        cyc(1);
      end
    end
    stall = 1'b1;
    cyc(30);
    for (n = 0; n < 8 && smp_ready_o === 1'b1; n = n + 1) begin
      smp_valid_i = 1'b1;
      smp_data_i = $urandom;
      @(posedge sys_clk_i);
      expq.push_back(smp_data_i);
      @(negedge sys_clk_i);
    end
    smp_valid_i = 1'b0;
    check(smp_ready_o, 0);
    stall = 1'b0;
    cyc(40);
    check(expq.size(), 0);
    press(0);
    press(1);
    check({aes_dir_out_o, src_enable_o}, 2);
    press(2);
    check(aes_dir_out_o, 0);
    cyc(10);
    press(1);
    commit(16'h0001, 16'h0001);
    check({led_mux_o, led_demux_o}, 4'h1);
    press(1);
    check(aes_dir_out_o, 1);
    press(0);
    press(0);
    for (i = 0; i < 3; i = i + 1) begin
      press(i == 2 ? 2 : 1);
      check(group_sel_o, i == 1 ? 0 : 3);
    end
    press(0);
    for (i = 0; i < 4; i = i + 1) begin
      press(1);
      check(pair_gain_o, i < 2 ? 3 + i : (i == 2 ? 4 : 12));
    end
    commit(16'hfff9, 16'h0199);
    check(led_gain_o, 8'h0a);
    srst_i = 1'b1;
    cyc(3);
    srst_i = 1'b0;
    cyc(20);
    check({aes_dir_valid_o, group_sel_o}, 3'h6);
    peak_sel_i = 3'h0;
    level_db_i = 32'h13;
    cyc(3);
    check(led_vu_o[1:0], `EFP_LED_ORANGE);
    print_verdict;
  end
endmodule // efp_ctrl_tb
